// ---- design/ilc_pkg.sv ----
package ilc_pkg;

  // clock and timer tick
  localparam int CLK_MHZ = 50;
  localparam int TICK_NS = 1000;
  localparam int TICK_DIV_DEF = (TICK_NS * CLK_MHZ) / 1000;

  // times are written in sixteenths of a tick and rounded to whole ticks
  localparam int TIME_W = 24;
  localparam int RND_FRAC = 4;
  localparam logic [TIME_W-1:0] RND_HALF = 24'h000008;
  typedef logic signed [TIME_W-1:0] tick_t;

  // writable register word indices (byte address = index * 4)
  localparam int NCFG = 14;
  localparam int IDX_CTRL = 0;
  localparam int IDX_TICK_DIV = 1;
  localparam int IDX_EXP_FIRST = 2;
  localparam int IDX_LDUR_FIRST = 4;
  localparam int IDX_LDLY_FIRST = 6;
  localparam int IDX_MDLY_FIRST = 8;
  localparam int IDX_EXP_MIN = 10;
  localparam int IDX_EXP_MAX = 11;
  localparam int IDX_READOUT = 12;
  localparam int IDX_SPACING = 13;

  // read-only register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_EFF_EXP = 8'h40;
  localparam logic [7:0] OFS_EFF_DLY = 8'h48;
  localparam logic [7:0] OFS_EFF_LDLY = 8'h50;
  localparam logic [7:0] OFS_EFF_LDUR = 8'h58;
  localparam logic [7:0] OFS_REARM = 8'h60;

  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_AREA = 1;
  localparam int CTRL_SCAN_LSB = 2;
  localparam int CTRL_OVL = 4;
  localparam int CTRL_DLY_LSB = 5;
  localparam int CTRL_CC_LSB = 7;
  localparam int CTRL_R1_LSB = 11;
  localparam int CTRL_R2_LSB = 13;

  // status register fields
  localparam int ST_VIOL = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_NEXT = 2;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h00004880;
  localparam logic [31:0] TICK_DIV_RST = 32'(TICK_DIV_DEF);
  localparam logic [31:0] EXP_MAX_RST = 32'h007fffff;

  localparam logic [1:0] ROUTE_ONE = 2'h1;
  localparam logic [1:0] ROUTE_TWO = 2'h2;

  typedef enum logic [1:0] {SCAN_FIXED, SCAN_CONT, SCAN_MULTI} scan_mode_t;
  typedef enum logic [1:0] {DLY_MANUAL, DLY_START, DLY_END} delay_mode_t;
  typedef enum logic {ST_IDLE, ST_RUN} run_state_t;

endpackage

// ---- design/interleaved_cycle_controller.sv ----
// How it works
// - programs alternate, first program begins
// - toggle returns to first at scan start
// - continuous scan resets once per sequence
// - fixed-length scan resets every phase
// - multi-phase scan resets only first phase
// - merged exposure reset routed to four lines
// - each light pulse routed one, two, none
// - shared output carries OR of pulses
// - line or frame trigger starts cycle
// - five timeline events per program
// - exposure, light and delay intervals defined
// - light delay signed from exposure start
// - events ordered, all before rearm point
// - early trigger reports violation
// - exposure clamped to min/max range
// - no overlap: next start after readout
// - overlap: next end after readout
// - reset spacing never below minimum
// - second rearm assumes first follows
// - first rearm takes worst successor in line trigger mode
// - manual delay raised to negated light delay
// - aligned modes match start or end
`timescale 1ns/1ps
`default_nettype none
module interleaved_cycle_controller
  import ilc_pkg::*;
#(
  parameter int PRE_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_trigger_i,
  input wire logic frame_trigger_i,
  input wire logic seq_start_i,
  input wire logic phase_start_i,
  output logic [3:0] cc_o,
  output logic isolated_output_one_o,
  output logic isolated_output_two_o,
  output logic trigger_violation_o
);

  function automatic tick_t rnd(input logic [TIME_W-1:0] v);
    tick_t s;
    // shift first and add the half bit after, so a full-scale value cannot overflow
    s = tick_t'(v) >>> RND_FRAC;
    if ((v & RND_HALF) != '0) begin
      s = s + tick_t'(1);
    end
    return s;
  endfunction

  function automatic tick_t mx(input tick_t a, input tick_t b);
    return (a > b) ? a : b;
  endfunction

  // ---------------- register bus and configuration ----------------
  logic [31:0] cfg_q [NCFG];
  logic [31:0] cfg_d [NCFG];
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic viol_q, viol_d;
  logic bus_req, bus_wr, viol_clr, viol_set;
  logic [5:0] widx;

  // effective per-program values, in ticks
  tick_t d_q [2], e_q [2], ld_q [2], lu_q [2], rearm_q [2];
  tick_t d_d [2], e_d [2], ld_d [2], lu_d [2], rearm_d [2];

  // run state
  run_state_t state_q, state_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  tick_t t_q, t_d;
  logic prog_q, prog_d, next_q, next_d;
  logic [2:0] sync_q, sync_d;
  logic [3:0] cc_q, cc_d;
  logic out1_q, out1_d, out2_q, out2_d;

  logic ctl_en, ctl_area, ctl_ovl;
  scan_mode_t scan_mode;
  delay_mode_t dly_mode;
  logic [3:0] cc_route;
  logic [1:0] route1, route2;
  logic trig_edge, tog_rst, accept, early, tick;
  tick_t xs_cur, xe_cur, ls_cur, le_cur, rearm_cur;
  logic rp_w, s1_w, s2_w;

  assign ctl_en = cfg_q[IDX_CTRL][CTRL_EN];
  assign ctl_area = cfg_q[IDX_CTRL][CTRL_AREA];
  assign ctl_ovl = cfg_q[IDX_CTRL][CTRL_OVL];
  assign scan_mode = scan_mode_t'(cfg_q[IDX_CTRL][CTRL_SCAN_LSB +: 2]);
  assign dly_mode = delay_mode_t'(cfg_q[IDX_CTRL][CTRL_DLY_LSB +: 2]);
  assign cc_route = cfg_q[IDX_CTRL][CTRL_CC_LSB +: 4];
  assign route1 = cfg_q[IDX_CTRL][CTRL_R1_LSB +: 2];
  assign route2 = cfg_q[IDX_CTRL][CTRL_R2_LSB +: 2];

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i;
  assign widx = wb_adr_i[7:2];
  assign viol_clr = bus_wr && (wb_adr_i == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_VIOL];

  always_comb begin
    for (int i = 0; i < NCFG; i++) begin
      cfg_d[i] = cfg_q[i];
      if (bus_wr && (widx == 6'(i))) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            cfg_d[i][8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
      end
    end
    ack_d = bus_req;
    rdat_d = 32'h00000000;
    if (bus_req && !wb_we_i) begin
      if (widx < 6'(NCFG)) begin
        rdat_d = cfg_q[widx[3:0]];
      end else begin
        // readback of rounded and computed values
        case (wb_adr_i)
          OFS_STATUS: rdat_d = {29'h0, next_q, (state_q == ST_RUN), viol_q};
          OFS_EFF_EXP: rdat_d = 32'(e_q[0]);
          OFS_EFF_EXP + 8'h04: rdat_d = 32'(e_q[1]);
          OFS_EFF_DLY: rdat_d = 32'(d_q[0]);
          OFS_EFF_DLY + 8'h04: rdat_d = 32'(d_q[1]);
          OFS_EFF_LDLY: rdat_d = 32'(signed'(ld_q[0]));
          OFS_EFF_LDLY + 8'h04: rdat_d = 32'(signed'(ld_q[1]));
          OFS_EFF_LDUR: rdat_d = 32'(lu_q[0]);
          OFS_EFF_LDUR + 8'h04: rdat_d = 32'(lu_q[1]);
          OFS_REARM: rdat_d = 32'(rearm_q[0]);
          OFS_REARM + 8'h04: rdat_d = 32'(rearm_q[1]);
          default: rdat_d = 32'h00000000;
        endcase
      end
    end
    // set wins over a simultaneous software clear
    viol_d = viol_q;
    if (viol_clr) begin
      viol_d = 1'b0;
    end
    if (viol_set) begin
      viol_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg_q[i] <= 32'h00000000;
      end
      cfg_q[IDX_CTRL] <= CTRL_RST;
      cfg_q[IDX_TICK_DIV] <= TICK_DIV_RST;
      cfg_q[IDX_EXP_MAX] <= EXP_MAX_RST;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      viol_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      viol_q <= viol_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign trigger_violation_o = viol_q;

  // ---------------- program timing computation ----------------
  tick_t emin, emax, ro, sp;
  tick_t md [2], dmin [2];
  tick_t end_al;

  // rearm point of a program whose successor has delay dn and exposure en
  function automatic tick_t rearm_of(input tick_t xs, input tick_t xe, input tick_t le,
                                     input tick_t dn, input tick_t en, input logic ovl,
                                     input tick_t rdo, input tick_t spc);
    tick_t r;
    r = mx(xe, le);
    // next start not before readout end
    // next end not before readout end
    r = mx(r, ovl ? (xe + rdo - dn - en) : (xe + rdo - dn));
    r = mx(r, xs + spc - dn);
    return mx(r, tick_t'(1));
  endfunction

  always_comb begin
    emin = mx(rnd(cfg_q[IDX_EXP_MIN][TIME_W-1:0]), tick_t'(1));
    emax = mx(rnd(cfg_q[IDX_EXP_MAX][TIME_W-1:0]), emin);
    ro = rnd(cfg_q[IDX_READOUT][TIME_W-1:0]);
    sp = rnd(cfg_q[IDX_SPACING][TIME_W-1:0]);
    for (int p = 0; p < 2; p++) begin
      e_d[p] = rnd(cfg_q[IDX_EXP_FIRST + p][TIME_W-1:0]);
      if (e_d[p] < emin) begin
        e_d[p] = emin;
      end
      if (e_d[p] > emax) begin
        e_d[p] = emax;
      end
      ld_d[p] = rnd(cfg_q[IDX_LDLY_FIRST + p][TIME_W-1:0]);
      lu_d[p] = mx(rnd(cfg_q[IDX_LDUR_FIRST + p][TIME_W-1:0]), tick_t'(1));
      md[p] = mx(rnd(cfg_q[IDX_MDLY_FIRST + p][TIME_W-1:0]), tick_t'(0));
      dmin[p] = mx(tick_t'(0), -ld_d[p]);
    end
    end_al = mx(dmin[0] + e_d[0], dmin[1] + e_d[1]);
    for (int p = 0; p < 2; p++) begin
      case (dly_mode)
        DLY_START: d_d[p] = mx(dmin[0], dmin[1]);
        DLY_END: d_d[p] = end_al - e_d[p];
        default: d_d[p] = mx(md[p], -ld_d[p]);
      endcase
    end
    rearm_d[1] = rearm_of(d_d[1], d_d[1] + e_d[1], d_d[1] + ld_d[1] + lu_d[1],
                          d_d[0], e_d[0], ctl_ovl, ro, sp);
    // first takes worst of both successors with the line trigger, only the second with the frame trigger
    rearm_d[0] = rearm_of(d_d[0], d_d[0] + e_d[0], d_d[0] + ld_d[0] + lu_d[0],
                          d_d[1], e_d[1], ctl_ovl, ro, sp);
    if (!ctl_area) begin
      rearm_d[0] = mx(rearm_d[0],
                      rearm_of(d_d[0], d_d[0] + e_d[0], d_d[0] + ld_d[0] + lu_d[0],
                               d_d[0], e_d[0], ctl_ovl, ro, sp));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 2; p++) begin
        d_q[p] <= '0;
        e_q[p] <= '0;
        ld_q[p] <= '0;
        lu_q[p] <= '0;
        rearm_q[p] <= '0;
      end
    end else begin
      d_q <= d_d;
      e_q <= e_d;
      ld_q <= ld_d;
      lu_q <= lu_d;
      rearm_q <= rearm_d;
    end
  end

  // ---------------- cycle execution ----------------
  // event positions of the running program
  assign xs_cur = d_q[prog_q];
  assign xe_cur = d_q[prog_q] + e_q[prog_q];
  assign ls_cur = d_q[prog_q] + ld_q[prog_q];
  assign le_cur = ls_cur + lu_q[prog_q];
  assign rearm_cur = rearm_q[prog_q];

  assign trig_edge = sync_q[1] && !sync_q[2];
  assign tick = (pre_q >= cfg_q[IDX_TICK_DIV][PRE_W-1:0] - PRE_W'(1));
  assign early = (state_q == ST_RUN) && (t_q < rearm_cur);
  assign accept = ctl_en && trig_edge && !early;
  assign viol_set = ctl_en && trig_edge && early;

  always_comb begin
    case (scan_mode)
      SCAN_CONT: tog_rst = seq_start_i;
      // first phase only, which opens the sequence
      SCAN_MULTI: tog_rst = seq_start_i;
      default: tog_rst = seq_start_i || phase_start_i;
    endcase
  end

  // intervals as windows on the timeline
  assign rp_w = (state_q == ST_RUN) && (t_q >= xs_cur) && (t_q < xe_cur);
  assign s1_w = (state_q == ST_RUN) && !prog_q && (t_q >= ls_cur) && (t_q < le_cur);
  assign s2_w = (state_q == ST_RUN) && prog_q && (t_q >= ls_cur) && (t_q < le_cur);

  always_comb begin
    sync_d = {sync_q[1:0], ctl_area ? frame_trigger_i : line_trigger_i};
    state_d = state_q;
    pre_d = tick ? '0 : pre_q + PRE_W'(1);
    t_d = (state_q == ST_RUN && tick) ? t_q + tick_t'(1) : t_q;
    prog_d = prog_q;
    next_d = tog_rst ? 1'b0 : next_q;
    if (state_q == ST_RUN && t_q >= rearm_cur) begin
      state_d = ST_IDLE;
    end
    // start the next program and flip the toggle
    if (accept) begin
      state_d = ST_RUN;
      prog_d = next_d;
      next_d = !next_d;
      t_d = '0;
      pre_d = '0;
    end
    if (!ctl_en) begin
      state_d = ST_IDLE;
    end
    // merged exposure reset to routed lines
    cc_d = {4{rp_w}} & cc_route;
    out1_d = (s1_w && route1 == ROUTE_ONE) || (s2_w && route2 == ROUTE_ONE);
    out2_d = (s1_w && route1 == ROUTE_TWO) || (s2_w && route2 == ROUTE_TWO);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 3'h0;
      state_q <= ST_IDLE;
      pre_q <= '0;
      t_q <= '0;
      prog_q <= 1'b0;
      next_q <= 1'b0;
      cc_q <= 4'h0;
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      state_q <= state_d;
      pre_q <= pre_d;
      t_q <= t_d;
      prog_q <= prog_d;
      next_q <= next_d;
      cc_q <= cc_d;
      out1_q <= out1_d;
      out2_q <= out2_d;
    end
  end

  assign cc_o = cc_q;
  assign isolated_output_one_o = out1_q;
  assign isolated_output_two_o = out2_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_single_pulse: assert property (ack_q |=> !ack_q)
    else $error("bus ack held longer than one cycle");

  chk_program_alternate: assert property (
    accept && !tog_rst |=> prog_q == $past(next_q) && next_q != $past(next_q))
    else $error("programs did not alternate");

  chk_scan_reset_first: assert property (
    tog_rst && !accept |=> !next_q)
    else $error("toggle not returned to first program");

  chk_continuous_phase_keep: assert property (
    scan_mode == SCAN_CONT && phase_start_i && !seq_start_i && !accept |=> $stable(next_q))
    else $error("continuous scan reset at a phase");

  chk_fixed_phase_reset: assert property (
    scan_mode == SCAN_FIXED && phase_start_i |=> ($past(accept) ? !prog_q : !next_q))
    else $error("fixed scan phase did not start on first program");

  chk_reset_start_time: assert property (
    $rose(|cc_o) |-> $past(t_q) == $past(xs_cur))
    else $error("exposure reset rose off its start event");

  chk_light_merge_out: assert property (
    route1 == ROUTE_ONE && route2 == ROUTE_ONE && (s1_w || s2_w) |=> isolated_output_one_o)
    else $error("merged light output missing pulse");

  chk_early_trigger_flag: assert property (
    viol_set |=> trigger_violation_o && $stable(prog_q) ##1 trigger_violation_o)
    else $error("early trigger not flagged or accepted");

  chk_exposure_clamp: assert property (
    !$past(rst_i) |-> e_q[0] >= tick_t'(1) && e_q[0] <= mx($past(emax), tick_t'(1)))
    else $error("effective exposure outside range");

  chk_rearm_after_end: assert property (
    rearm_q[0] >= d_q[0] + e_q[0] && rearm_q[1] >= d_q[1] + lu_q[1] + ld_q[1])
    else $error("rearm point before program end");

  chk_light_not_early: assert property (
    d_q[0] + ld_q[0] >= tick_t'(0) && d_q[1] + ld_q[1] >= tick_t'(0))
    else $error("light on before the trigger");

endmodule
`default_nettype wire

// ---- tb/camera_light_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module camera_light_model (
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic fire_i,
  input wire logic area_i,
  input wire logic [3:0] cc_i,
  input wire logic one_i,
  input wire logic two_i,
  output logic line_trigger_o,
  output logic frame_trigger_o,
  output logic [2:0][15:0] width_o,
  output logic [2:0][7:0] count_o,
  output logic [3:0] cc_seen_o
);
  logic [2:0][15:0] run_q;
  logic [2:0] level;
  logic [2:0] hold_q;
  assign level = {two_i, one_i, |cc_i};
  // pin held several clocks so the input synchroniser cannot miss it
  assign line_trigger_o = (hold_q != 3'h0) && !area_i;
  assign frame_trigger_o = (hold_q != 3'h0) && area_i;
  always_ff @(posedge clk_i) begin
    hold_q <= fire_i ? 3'h4 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
    cc_seen_o <= cc_seen_o | cc_i;
    // camera and lamps measure each pulse they receive
    for (int i = 0; i < 3; i++) begin
      if (level[i]) begin
        run_q[i] <= run_q[i] + 16'h1;
      end else if (run_q[i] != 16'h0) begin
        width_o[i] <= run_q[i];
        count_o[i] <= count_o[i] + 8'h1;
        run_q[i] <= 16'h0;
      end
    end
    if (clear_i) begin
      run_q <= '0;
      width_o <= '0;
      count_o <= '0;
      cc_seen_o <= 4'h0;
      hold_q <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ilc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rd;
  logic [31:0] rdata;
  logic wb_ack, one, two, viol, line_trg, frame_trg;
  logic seq = 1'b0;
  logic phase = 1'b0;
  logic clear = 1'b1;
  logic fire = 1'b0;
  logic area = 1'b0;
  logic [3:0] cc, seen;
  logic [2:0][15:0] width;
  logic [2:0][7:0] count;
  int fail_count = 0;
  int checks_done = 0;

  interleaved_cycle_controller #(.PRE_W(16)) i_interleaved_cycle_controller (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .line_trigger_i(line_trg), .frame_trigger_i(frame_trg), .seq_start_i(seq),
    .phase_start_i(phase), .cc_o(cc), .isolated_output_one_o(one),
    .isolated_output_two_o(two), .trigger_violation_o(viol));

  camera_light_model i_camera_light_model (
    .clk_i(clk_i), .clear_i(clear), .fire_i(fire), .area_i(area), .cc_i(cc), .one_i(one),
    .two_i(two), .line_trigger_o(line_trg), .frame_trigger_o(frame_trg), .width_o(width),
    .count_o(count), .cc_seen_o(seen));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task mis(input string m);
    fail_count++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) mis("no bus ack");
    rdata = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task check_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'h00ffffff);
    wb(1'b0, a, 32'h0);
    checks_done++;
    if ((rdata & m) !== e) mis($sformatf("reg %h got %h want %h", a, rdata & m, e));
  endtask

  task check_val(input logic [15:0] g, input logic [15:0] e, input string w);
    checks_done++;
    if (g !== e) mis($sformatf("%s got %0d want %0d", w, g, e));
  endtask

  task wctl(input scan_mode_t s, input logic o, input delay_mode_t d, input logic [3:0] c,
            input logic [1:0] r1, input logic [1:0] r2, input logic ar);
    wb(1'b1, 8'h00, {17'h0, r2, r1, c, d, o, s, ar, 1'b1});
  endtask

  // gap covers synchroniser plus the longest program at two clocks a tick
  task fire_trig(input logic a, input int gap);
    @(posedge clk_i);
    area <= a;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask

  task pulse(input logic s);
    @(posedge clk_i);
    if (s) seq <= 1'b1;
    else phase <= 1'b1;
    @(posedge clk_i);
    seq <= 1'b0;
    phase <= 1'b0;
  endtask

  task clr;
    @(posedge clk_i);
    clear <= 1'b1;
    @(posedge clk_i);
    clear <= 1'b0;
  endtask

  task t_reset;
    check_val({9'h0, cc, one, two, viol}, 16'h0, "pins idle");
    check_reg(8'h00, CTRL_RST, 32'hffffffff);
    check_reg(8'h04, TICK_DIV_RST, 32'hffffffff);
    check_reg(8'h2c, EXP_MAX_RST, 32'hffffffff);
    check_reg(8'hfc, 32'h0, 32'hffffffff);
    $display("test reset done");
  endtask

  task t_config;
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b1, 8'h08, 32'h2c);
    wb(1'b1, 8'h0c, 32'h50);
    wb(1'b1, 8'h10, 32'h20);
    wb(1'b1, 8'h14, 32'h40);
    wb(1'b1, 8'h18, 32'h0);
    wb(1'b1, 8'h1c, 32'h00ffffe0);
    wb(1'b1, 8'h20, 32'h0);
    wb(1'b1, 8'h24, 32'h10);
    wb(1'b1, 8'h28, 32'h10);
    wb(1'b1, 8'h30, 32'h0);
    wb(1'b1, 8'h34, 32'h0);
    check_reg(8'h40, 32'h3); // rounded
    check_reg(8'h44, 32'h5); // whole
    check_reg(8'h54, 32'h00fffffe); // negative
    check_reg(8'h48, 32'h0); // default
    check_reg(8'h4c, 32'h2); // raised
    wb(1'b1, 8'h20, 32'h50);
    check_reg(8'h48, 32'h5); // manual
    wb(1'b1, 8'h20, 32'h0);
    wb(1'b1, 8'h28, 32'h40);
    wb(1'b1, 8'h08, 32'h20);
    check_reg(8'h40, 32'h4); // low
    wb(1'b1, 8'h2c, 32'h80);
    wb(1'b1, 8'h08, 32'h140);
    check_reg(8'h40, 32'h8); // high
    wb(1'b1, 8'h28, 32'h10);
    wb(1'b1, 8'h2c, 32'h007fffff);
    wb(1'b1, 8'h08, 32'h2c);
    $display("test config done");
  endtask

  task t_alternate;
    logic [15:0] exp_w [3];
    exp_w = '{16'd6, 16'd10, 16'd6};
    wctl(SCAN_FIXED, 1'b0, DLY_MANUAL, 4'hf, 2'h1, 2'h2, 1'b0);
    pulse(1'b1);
    clr();
    for (int i = 0; i < 3; i++) begin
      fire_trig(1'b0, 60);
      check_val(width[0], exp_w[i], "reset width"); // order
    end
    check_val(width[1], 16'd4, "light one width"); // light
    check_val(width[2], 16'd8, "light two width"); // light
    check_val(count[1], 8'd2, "light one count"); // route
    check_val(count[2], 8'd1, "light two count"); // route
    $display("test alternate done");
  endtask

  task t_route;
    wctl(SCAN_FIXED, 1'b0, DLY_MANUAL, 4'h5, 2'h1, 2'h1, 1'b0);
    clr();
    fire_trig(1'b0, 60);
    fire_trig(1'b0, 60);
    check_val(count[1], 8'd2, "merged count"); // merge
    check_val(count[2], 8'd0, "unused line"); // merge
    check_val(seen, 4'h5, "cc mask"); // lines
    wctl(SCAN_FIXED, 1'b0, DLY_MANUAL, 4'h2, 2'h0, 2'h0, 1'b0);
    clr();
    fire_trig(1'b0, 60);
    check_val({count[1], count[2]}, 16'h0, "no light"); // none
    check_val(seen, 4'h2, "cc mask two"); // lines
    $display("test route done");
  endtask

  task t_violation;
    wctl(SCAN_FIXED, 1'b0, DLY_MANUAL, 4'h1, 2'h1, 2'h2, 1'b0);
    clr();
    fire_trig(1'b0, 3); // second edge lands before rearm
    fire_trig(1'b0, 60);
    check_val(count[0], 8'd1, "early ignored"); // refused
    check_val(viol, 1'b1, "violation pin"); // flag
    check_reg(OFS_STATUS, 32'h1, 32'h1); // status
    wb(1'b1, OFS_STATUS, 32'h1);
    check_reg(OFS_STATUS, 32'h0, 32'h1); // cleared
    check_val(viol, 1'b0, "violation cleared"); // cleared
    $display("test violation done");
  endtask

  task t_scan;
    logic [31:0] after_phase [3];
    after_phase = '{32'h0, 32'h4, 32'h4};
    for (int i = 0; i < 3; i++) begin
      wctl(scan_mode_t'(i), 1'b0, DLY_MANUAL, 4'h1, 2'h1, 2'h2, 1'b0);
      pulse(1'b1);
      fire_trig(1'b0, 60);
      check_reg(OFS_STATUS, 32'h4, 32'h4); // toggled
      pulse(1'b0);
      check_reg(OFS_STATUS, after_phase[i], 32'h4); // phase
      fire_trig(1'b0, 60);
      pulse(1'b1);
      check_reg(OFS_STATUS, 32'h0, 32'h4); // scan start
    end
    $display("test scan done");
  endtask

  task t_area;
    wctl(SCAN_FIXED, 1'b0, DLY_MANUAL, 4'h1, 2'h1, 2'h2, 1'b1);
    clr();
    fire_trig(1'b0, 60);
    check_val(count[0], 8'd0, "line pin ignored"); // source
    fire_trig(1'b1, 60);
    check_val(count[0], 8'd1, "frame pin starts"); // source
    area <= 1'b0;
    $display("test area done");
  endtask

  task t_rearm;
    wb(1'b1, 8'h30, 32'ha0);
    wctl(SCAN_FIXED, 1'b0, DLY_MANUAL, 4'h1, 2'h1, 2'h2, 1'b0);
    check_reg(OFS_REARM, 32'd13); // worst
    check_reg(OFS_REARM + 8'h4, 32'd17); // next
    wb(1'b1, 8'h34, 32'h140);
    check_reg(OFS_REARM, 32'd20); // spacing
    check_reg(OFS_REARM + 8'h4, 32'd22); // spacing
    wb(1'b1, 8'h34, 32'h0);
    wctl(SCAN_FIXED, 1'b1, DLY_MANUAL, 4'h1, 2'h1, 2'h2, 1'b0);
    check_reg(OFS_REARM, 32'd10); // worst
    check_reg(OFS_REARM + 8'h4, 32'd14); // next
    wctl(SCAN_FIXED, 1'b0, DLY_START, 4'h1, 2'h1, 2'h2, 1'b0);
    check_reg(OFS_EFF_DLY, 32'd2); // start
    check_reg(OFS_EFF_DLY + 8'h4, 32'd2); // start
    wctl(SCAN_FIXED, 1'b0, DLY_END, 4'h1, 2'h1, 2'h2, 1'b0);
    check_reg(OFS_EFF_DLY, 32'd4); // end
    check_reg(OFS_EFF_DLY + 8'h4, 32'd2); // end
    wb(1'b1, 8'h30, 32'h0);
    $display("test rearm done");
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    clear <= 1'b0;
    t_reset();
    t_config();
    t_alternate();
    t_route();
    t_violation();
    t_scan();
    t_area();
    t_rearm();
    results();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    mis("watchdog expired");
    results();
  end
endmodule
`default_nettype wire
